// File: design/sfrb0_regmap.sv
// bank-zero special register map with a classic Wishbone slave
//
// Operation
// - unimplemented addresses and bits read zero
// - timer1 count split low/high byte registers
// - reset loads each listed value
// - decode offsets 00h..1Fh to registers
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
`include "sfrb0_defines.svh"

module sfrb0_regmap
  import sfrb0_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [6:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // indirect data memory port
  output logic      [7:0]  indirect_addr_o,
  output logic             indirect_we_o,
  output logic             indirect_re_o,
  output logic      [7:0]  indirect_wdata_o,
  input  wire logic [7:0]  indirect_rdata_i,
  // peripheral state
  input  wire logic [15:0] timer1_counter_i,
  input  wire logic        timer1_load_i,
  input  wire logic [9:0]  converter_result_i,
  input  wire logic [5:0]  port_a_pins_i,
  input  wire logic [5:0]  port_c_pins_i,
  // control bytes to peripherals
  output logic      [7:0]  timer0_count_o,
  output logic      [7:0]  program_counter_low_o,
  output logic      [7:0]  core_status_flags_o,
  output logic      [5:0]  port_a_latch_o,
  output logic      [5:0]  port_c_latch_o,
  output logic      [4:0]  program_counter_high_buffer_o,
  output logic      [7:0]  interrupt_control_o,
  output logic      [7:0]  peripheral_irq_flags_o,
  output logic      [15:0] timer1_counter_o,
  output logic             timer1_write_o,
  output logic      [7:0]  timer1_control_o,
  output logic      [7:0]  timer2_count_o,
  output logic      [6:0]  timer2_control_o,
  output logic      [15:0] capture_compare_o,
  output logic      [7:0]  capture_compare_control_o,
  output logic      [7:0]  pwm_deadband_control_o,
  output logic      [7:0]  pwm_autoshutdown_control_o,
  output logic      [7:0]  voltage_reference_control_o,
  output logic      [7:0]  comparator_one_control_o,
  output logic      [7:0]  comparator_two_control_o,
  output logic      [7:0]  comparator_shared_config_o,
  output logic      [7:0]  converter_control_o
);

  ////////////////////////////////////////////////////////////////////////////
  sfrb0_state_t state_reg;
  sfrb0_off_t   off;
  logic         req;
  logic         wr;
  logic         rd;
  sfrb0_byte_t  wbyte;
  sfrb0_byte_t  rdata_next;
  sfrb0_byte_t  rdata_reg;

  sfrb0_byte_t t0cnt_reg, pclo_reg, status_reg, ptr_reg;
  sfrb0_byte_t pinsa_reg, pinsc_reg, pch_reg, intctl_reg, pirq_reg;
  sfrb0_byte_t t1l_reg, t1h_reg, t1ctl_reg, t2_reg, t2ctl_reg;
  sfrb0_byte_t ccl_reg, cch_reg, ccctl_reg, pwmdb_reg, pwmas_reg;
  sfrb0_byte_t vref_reg, cmp1_reg, cmp2_reg, cmpcfg_reg, adctl_reg;
  logic        t1_wr_reg;

  assign off   = wb_adr_i[6:2];
  assign req   = wb_cyc_i && wb_stb_i && (state_reg == SFRB0_IDLE);
  // only lane 0 carries the byte; other lanes are ignored
  assign wr    = req && wb_we_i && wb_sel_i[0];
  assign rd    = req && !wb_we_i;
  assign wbyte = wb_dat_i[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // one wait state: ack one cycle after the request, dropped next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= SFRB0_IDLE;
    end else begin
      case (state_reg)
        SFRB0_IDLE: begin
          if (wb_cyc_i && wb_stb_i) begin
            state_reg <= SFRB0_ACK;
          end
        end
        SFRB0_ACK: state_reg <= SFRB0_IDLE;
        default:   state_reg <= SFRB0_IDLE;
      endcase
    end
  end

  assign wb_ack_o = (state_reg == SFRB0_ACK);
  assign wb_dat_o = {24'h000000, rdata_reg};

  ////////////////////////////////////////////////////////////////////////////
  // indirect access path
  assign indirect_addr_o  = ptr_reg;
  assign indirect_we_o    = wr && (off == `SFRB0_OFF_INDIRECT);
  assign indirect_re_o    = rd && (off == `SFRB0_OFF_INDIRECT);
  assign indirect_wdata_o = wbyte;

  ////////////////////////////////////////////////////////////////////////////
  // register storage, one process per peripheral group
  // core reset values
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      t0cnt_reg  <= `SFRB0_RST_ZERO;
      pclo_reg   <= `SFRB0_RST_ZERO;
      status_reg <= `SFRB0_RST_STATUS;
      ptr_reg    <= `SFRB0_RST_ZERO;
    end else if (wr) begin
      case (off)
        `SFRB0_OFF_T0CNT:  t0cnt_reg  <= wbyte;
        `SFRB0_OFF_PCLO:   pclo_reg   <= wbyte;
        // power-down and time-out flags are core-owned, not writable here
        `SFRB0_OFF_STATUS: begin
          status_reg <= (status_reg & ~`SFRB0_MASK_STATUS_WR)
                      | (wbyte & `SFRB0_MASK_STATUS_WR);
        end
        `SFRB0_OFF_PTR:    ptr_reg    <= wbyte;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // writes land in the latch; reads see the pins
  // port latch reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pinsa_reg  <= `SFRB0_RST_ZERO;
      pinsc_reg  <= `SFRB0_RST_ZERO;
    end else if (wr) begin
      case (off)
        `SFRB0_OFF_PINSA:  pinsa_reg  <= wbyte & `SFRB0_MASK_PORT;
        `SFRB0_OFF_PINSC:  pinsc_reg  <= wbyte & `SFRB0_MASK_PORT;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // program and interrupt reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pch_reg    <= `SFRB0_RST_ZERO;
      intctl_reg <= `SFRB0_RST_ZERO;
      pirq_reg   <= `SFRB0_RST_ZERO;
    end else if (wr) begin
      case (off)
        `SFRB0_OFF_PCH:    pch_reg    <= wbyte & `SFRB0_MASK_PCH;
        `SFRB0_OFF_INTCTL: intctl_reg <= wbyte;
        `SFRB0_OFF_PIRQ:   pirq_reg   <= wbyte & `SFRB0_MASK_PIRQ;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timer control reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      t1ctl_reg  <= `SFRB0_RST_ZERO;
      t2_reg     <= `SFRB0_RST_ZERO;
      t2ctl_reg  <= `SFRB0_RST_ZERO;
    end else if (wr) begin
      case (off)
        `SFRB0_OFF_T1CTL:  t1ctl_reg  <= wbyte;
        `SFRB0_OFF_T2:     t2_reg     <= wbyte;
        `SFRB0_OFF_T2CTL:  t2ctl_reg  <= wbyte & `SFRB0_MASK_T2CTL;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // capture and pwm bytes are plain storage for the timing logic
  // capture pwm reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ccl_reg    <= `SFRB0_RST_ZERO;
      cch_reg    <= `SFRB0_RST_ZERO;
      ccctl_reg  <= `SFRB0_RST_ZERO;
      pwmdb_reg  <= `SFRB0_RST_ZERO;
      pwmas_reg  <= `SFRB0_RST_ZERO;
    end else if (wr) begin
      case (off)
        `SFRB0_OFF_CCL:    ccl_reg    <= wbyte;
        `SFRB0_OFF_CCH:    cch_reg    <= wbyte;
        `SFRB0_OFF_CCCTL:  ccctl_reg  <= wbyte;
        `SFRB0_OFF_PWMDB:  pwmdb_reg  <= wbyte;
        `SFRB0_OFF_PWMAS:  pwmas_reg  <= wbyte;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog control reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vref_reg   <= `SFRB0_RST_ZERO;
      cmp1_reg   <= `SFRB0_RST_ZERO;
      cmp2_reg   <= `SFRB0_RST_ZERO;
      cmpcfg_reg <= `SFRB0_RST_CMPCFG;
      adctl_reg  <= `SFRB0_RST_ZERO;
    end else if (wr) begin
      case (off)
        `SFRB0_OFF_VREF:   vref_reg   <= wbyte;
        // comparator output bits stay read-only
        `SFRB0_OFF_CMP1:   cmp1_reg   <= wbyte & `SFRB0_MASK_CMP_WR;
        `SFRB0_OFF_CMP2:   cmp2_reg   <= wbyte & `SFRB0_MASK_CMP_WR;
        `SFRB0_OFF_CMPCFG: cmpcfg_reg <= wbyte & `SFRB0_MASK_CMPCFG_WR;
        `SFRB0_OFF_ADCTL:  adctl_reg  <= wbyte;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timer1 holding bytes, bus write wins over a counter load
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      t1l_reg   <= `SFRB0_RST_ZERO;
      t1h_reg   <= `SFRB0_RST_ZERO;
      t1_wr_reg <= 1'b0;
    end else begin
      t1_wr_reg <= wr && (off == `SFRB0_OFF_T1L || off == `SFRB0_OFF_T1H);
      if (wr && off == `SFRB0_OFF_T1L) begin
        t1l_reg <= wbyte;
      end else if (timer1_load_i) begin
        t1l_reg <= timer1_counter_i[7:0];
      end
      if (wr && off == `SFRB0_OFF_T1H) begin
        t1h_reg <= wbyte;
      end else if (timer1_load_i) begin
        t1h_reg <= timer1_counter_i[15:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux, unmapped offsets fall to zero
  always_comb begin
    rdata_next = 8'h00;
    case (off)
      `SFRB0_OFF_INDIRECT: rdata_next = indirect_rdata_i;
      `SFRB0_OFF_T0CNT:    rdata_next = t0cnt_reg;
      `SFRB0_OFF_PCLO:     rdata_next = pclo_reg;
      `SFRB0_OFF_STATUS:   rdata_next = status_reg & `SFRB0_MASK_STATUS;
      `SFRB0_OFF_PTR:      rdata_next = ptr_reg;
      `SFRB0_OFF_PINSA:    rdata_next = {2'b00, port_a_pins_i};
      `SFRB0_OFF_PINSC:    rdata_next = {2'b00, port_c_pins_i};
      `SFRB0_OFF_PCH:      rdata_next = pch_reg & `SFRB0_MASK_PCH;
      `SFRB0_OFF_INTCTL:   rdata_next = intctl_reg;
      `SFRB0_OFF_PIRQ:     rdata_next = pirq_reg & `SFRB0_MASK_PIRQ;
      `SFRB0_OFF_T1L:      rdata_next = t1l_reg;
      `SFRB0_OFF_T1H:      rdata_next = t1h_reg;
      `SFRB0_OFF_T1CTL:    rdata_next = t1ctl_reg;
      `SFRB0_OFF_T2:       rdata_next = t2_reg;
      `SFRB0_OFF_T2CTL:    rdata_next = t2ctl_reg & `SFRB0_MASK_T2CTL;
      `SFRB0_OFF_CCL:      rdata_next = ccl_reg;
      `SFRB0_OFF_CCH:      rdata_next = cch_reg;
      `SFRB0_OFF_CCCTL:    rdata_next = ccctl_reg;
      `SFRB0_OFF_PWMDB:    rdata_next = pwmdb_reg;
      `SFRB0_OFF_PWMAS:    rdata_next = pwmas_reg;
      `SFRB0_OFF_VREF:     rdata_next = vref_reg;
      `SFRB0_OFF_CMP1:     rdata_next = cmp1_reg & `SFRB0_MASK_CMP;
      `SFRB0_OFF_CMP2:     rdata_next = cmp2_reg & `SFRB0_MASK_CMP;
      `SFRB0_OFF_CMPCFG:   rdata_next = cmpcfg_reg & `SFRB0_MASK_CMPCFG;
      `SFRB0_OFF_ADRH: begin
        if (adctl_reg[`SFRB0_BIT_ADFM]) begin
          rdata_next = {6'h00, converter_result_i[9:8]};
        end else begin
          rdata_next = converter_result_i[9:2];
        end
      end
      `SFRB0_OFF_ADCTL:    rdata_next = adctl_reg;
      default:             rdata_next = 8'h00;
    endcase
    // misaligned byte addresses read zero
    if (wb_adr_i[1:0] != 2'b00) begin
      rdata_next = 8'h00;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= 8'h00;
    end else if (rd) begin
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign timer0_count_o               = t0cnt_reg;
  assign program_counter_low_o        = pclo_reg;
  // reserved bank bits 7:6 are not writable and stay zero; the status byte goes out unmasked
  assign core_status_flags_o          = status_reg;
  assign port_a_latch_o               = pinsa_reg[5:0];
  assign port_c_latch_o               = pinsc_reg[5:0];
  assign program_counter_high_buffer_o = pch_reg[4:0];
  assign interrupt_control_o          = intctl_reg;
  assign peripheral_irq_flags_o       = pirq_reg;
  assign timer1_counter_o             = {t1h_reg, t1l_reg};
  assign timer1_write_o               = t1_wr_reg;
  assign timer1_control_o             = t1ctl_reg;
  assign timer2_count_o               = t2_reg;
  assign timer2_control_o             = t2ctl_reg[6:0];
  assign capture_compare_o            = {cch_reg, ccl_reg};
  assign capture_compare_control_o    = ccctl_reg;
  assign pwm_deadband_control_o       = pwmdb_reg;
  assign pwm_autoshutdown_control_o   = pwmas_reg;
  assign voltage_reference_control_o  = vref_reg;
  assign comparator_one_control_o     = cmp1_reg;
  assign comparator_two_control_o     = cmp2_reg;
  assign comparator_shared_config_o   = cmpcfg_reg;
  assign converter_control_o          = adctl_reg;

endmodule
`default_nettype wire

// File: pkg/sfrb0_defines.svh
// register offsets, implemented-bit masks and reset values for the bank-zero register map
`ifndef SFRB0_DEFINES_SVH
`define SFRB0_DEFINES_SVH

`define SFRB0_OFF_INDIRECT  5'h00
`define SFRB0_OFF_T0CNT     5'h01
`define SFRB0_OFF_PCLO      5'h02
`define SFRB0_OFF_STATUS    5'h03
`define SFRB0_OFF_PTR       5'h04
`define SFRB0_OFF_PINSA     5'h05
`define SFRB0_OFF_PINSC     5'h07
`define SFRB0_OFF_PCH       5'h0a
`define SFRB0_OFF_INTCTL    5'h0b
`define SFRB0_OFF_PIRQ      5'h0c
`define SFRB0_OFF_T1L       5'h0e
`define SFRB0_OFF_T1H       5'h0f
`define SFRB0_OFF_T1CTL     5'h10
`define SFRB0_OFF_T2        5'h11
`define SFRB0_OFF_T2CTL     5'h12
`define SFRB0_OFF_CCL       5'h13
`define SFRB0_OFF_CCH       5'h14
`define SFRB0_OFF_CCCTL     5'h15
`define SFRB0_OFF_PWMDB     5'h16
`define SFRB0_OFF_PWMAS     5'h17
`define SFRB0_OFF_VREF      5'h19
`define SFRB0_OFF_CMP1      5'h1a
`define SFRB0_OFF_CMP2      5'h1b
`define SFRB0_OFF_CMPCFG    5'h1c
`define SFRB0_OFF_ADRH      5'h1e
`define SFRB0_OFF_ADCTL     5'h1f

// implemented-bit masks (unimplemented bits read zero)
`define SFRB0_MASK_PORT     8'h3f
`define SFRB0_MASK_PCH      8'h1f
`define SFRB0_MASK_PIRQ     8'h7b
`define SFRB0_MASK_T2CTL    8'h7f
`define SFRB0_MASK_CMP      8'hf7
`define SFRB0_MASK_CMPCFG   8'hdf
// status bits 2..0 are unknown at reset; zero is taken
`define SFRB0_MASK_STATUS   8'hff
`define SFRB0_MASK_STATUS_WR 8'h27
`define SFRB0_MASK_CMP_WR   8'hb7
`define SFRB0_MASK_CMPCFG_WR 8'h1f

`define SFRB0_RST_ZERO      8'h00
`define SFRB0_RST_STATUS    8'h18
`define SFRB0_RST_CMPCFG    8'h02

`define SFRB0_BIT_ADFM      7
`define SFRB0_WB_ADDR_LSB   2
`endif

// File: pkg/sfrb0_pkg.sv
// types shared by the bank-zero register map
package sfrb0_pkg;
  typedef logic [7:0] sfrb0_byte_t;
  typedef logic [4:0] sfrb0_off_t;
  typedef enum logic [1:0] {
    SFRB0_IDLE,
    SFRB0_ACK
  } sfrb0_state_t;
endpackage

// File: verif/bank0_special_register_map_test.sv
// self-checking bench for the bank-zero register map
`timescale 1ns/1ns
`default_nettype none
module bank0_special_register_map_test
  import sfrb0_pkg::*;
;
  logic        clk_i, rst_i, cyc, stb, we, ack, i_we, i_re, t1_load;
  logic [6:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat, dout, rdat;
  logic [7:0]  i_addr, i_wd, i_rd;
  logic [15:0] t1_cnt;
  logic [9:0]  res;
  logic [5:0]  pa, pc;
  logic [7:0]  q_t0, q_pclo, q_st, q_ic, q_pf, q_t1c, q_t2, q_ccc, q_pdb, q_pas, q_vr;
  logic [7:0]  q_c1, q_c2, q_cs, q_ad;
  logic [15:0] q_t1, q_cc;
  logic [6:0]  q_t2c;
  logic [5:0]  q_la, q_lc;
  logic [4:0]  q_pch;
  sfrb0_byte_t shad [32];
  sfrb0_byte_t d;
  int          failures, comparisons;

  sfrb0_regmap uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack),
    .indirect_addr_o(i_addr), .indirect_we_o(i_we), .indirect_re_o(i_re),
    .indirect_wdata_o(i_wd), .indirect_rdata_i(i_rd), .timer1_counter_i(t1_cnt),
    .timer1_load_i(t1_load), .converter_result_i(res), .port_a_pins_i(pa),
    .port_c_pins_i(pc), .timer0_count_o(q_t0), .program_counter_low_o(q_pclo),
    .core_status_flags_o(q_st), .port_a_latch_o(q_la), .port_c_latch_o(q_lc),
    .program_counter_high_buffer_o(q_pch), .interrupt_control_o(q_ic),
    .peripheral_irq_flags_o(q_pf), .timer1_counter_o(q_t1), .timer1_write_o(),
    .timer1_control_o(q_t1c), .timer2_count_o(q_t2), .timer2_control_o(q_t2c),
    .capture_compare_o(q_cc), .capture_compare_control_o(q_ccc),
    .pwm_deadband_control_o(q_pdb), .pwm_autoshutdown_control_o(q_pas),
    .voltage_reference_control_o(q_vr), .comparator_one_control_o(q_c1),
    .comparator_two_control_o(q_c2), .comparator_shared_config_o(q_cs),
    .converter_control_o(q_ad));
  sfrb0_mem_model mdl (.clk_i(clk_i), .addr_i(i_addr), .we_i(i_we), .re_i(i_re),
    .wdata_i(i_wd), .rdata_o(i_rd));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////
  function automatic sfrb0_byte_t exp(input logic [4:0] o);
    case (o)
      5'h03: return (shad[o] & 8'h27) | 8'h18;
      5'h05: return {2'h0, pa};
      5'h07: return {2'h0, pc};
      5'h06, 5'h08, 5'h09, 5'h0d, 5'h18, 5'h1d: return 8'h00;
      5'h0a, 5'h1c: return shad[o] & 8'h1f;
      5'h0c: return shad[o] & 8'h7b;
      5'h12: return shad[o] & 8'h7f;
      5'h1a, 5'h1b: return shad[o] & 8'hb7;
      5'h1e: return shad[31][7] ? {6'h0, res[9:8]} : res[9:2];
      default: return shad[o];
    endcase
  endfunction
  task automatic print_verdict();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input sfrb0_byte_t e, input logic [31:0] g);
    comparisons++;
    if (g !== {24'h0, e}) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // control outputs follow the stored bytes
  task automatic chk_outs();
    chk("timer0 out", exp(5'h01), {24'h0, q_t0});
    chk("pc low out", exp(5'h02), {24'h0, q_pclo});
    chk("status out", exp(5'h03), {24'h0, q_st});
    chk("latch a out", shad[5] & 8'h3f, {26'h0, q_la});
    chk("latch c out", shad[7] & 8'h3f, {26'h0, q_lc});
    chk("pc high out", exp(5'h0a), {27'h0, q_pch});
    chk("irq ctl out", exp(5'h0b), {24'h0, q_ic});
    chk("irq flag out", exp(5'h0c), {24'h0, q_pf});
    chk("timer1 low out", exp(5'h0e), {24'h0, q_t1[7:0]});
    chk("timer1 high out", exp(5'h0f), {24'h0, q_t1[15:8]});
    chk("t1 ctl out", exp(5'h10), {24'h0, q_t1c});
    chk("timer2 out", exp(5'h11), {24'h0, q_t2});
    chk("t2 ctl out", exp(5'h12), {25'h0, q_t2c});
    chk("capture low out", exp(5'h13), {24'h0, q_cc[7:0]});
    chk("capture high out", exp(5'h14), {24'h0, q_cc[15:8]});
    chk("capture ctl out", exp(5'h15), {24'h0, q_ccc});
    chk("deadband out", exp(5'h16), {24'h0, q_pdb});
    chk("shutdown out", exp(5'h17), {24'h0, q_pas});
    chk("vref out", exp(5'h19), {24'h0, q_vr});
    chk("cmp1 out", exp(5'h1a), {24'h0, q_c1});
    chk("cmp2 out", exp(5'h1b), {24'h0, q_c2});
    chk("cmp cfg out", exp(5'h1c), {24'h0, q_cs});
    chk("adc ctl out", exp(5'h1f), {24'h0, q_ad});
  endtask
  // request held until ack is sampled; bounded wait
  task automatic bus(input logic w, input logic [6:0] a, input sfrb0_byte_t v,
                     input logic [3:0] s = 4'hf);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= s;
    adr <= a;
    dat <= {24'h0, v};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin
      failures++;
      print_verdict();
    end
    rdat = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rc(input logic [4:0] o);
    bus(1'b0, {o, 2'h0}, 8'h00);
    chk($sformatf("offset %h", o), exp(o), rdat);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {rst_i, sel} = 5'h1f;
    {cyc, stb, we, t1_load, adr, dat, t1_cnt, res, pa, pc} = '0;
    failures = 0;
    comparisons = 0;
    foreach (shad[i]) shad[i] = 8'h00;
    shad[28] = 8'h02;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    void'($urandom(14));
    pa <= 6'($urandom);
    pc <= 6'($urandom);
    res <= 10'($urandom);
    for (int o = 1; o < 32; o++) rc(o[4:0]);
    chk_outs();
    for (int p = 0; p < 2; p++) begin
      for (int o = 1; o < 32; o++) begin
        d = 8'($urandom);
        if (o == 3) d[7:6] = 2'h0;
        if (o == 31) d[7] = p[0];
        bus(1'b1, {o[4:0], 2'h0}, d);
        shad[o] = d;
      end
      for (int o = 1; o < 32; o++) rc(o[4:0]);
      chk_outs();
    end
    for (int k = 0; k < 4; k++) begin
      d = 8'($urandom);
      bus(1'b1, 7'h10, d);
      bus(1'b1, 7'h00, ~d);
      bus(1'b0, 7'h00, 8'h00);
      chk("indirect", ~d, rdat);
    end
    t1_cnt <= 16'($urandom);
    t1_load <= 1'b1;
    @(posedge clk_i);
    t1_load <= 1'b0;
    shad[14] = t1_cnt[7:0];
    shad[15] = t1_cnt[15:8];
    rc(5'h0e);
    rc(5'h0f);
    // mid-run reset must restore every listed value
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (shad[i]) shad[i] = 8'h00;
    shad[28] = 8'h02;
    for (int o = 1; o < 32; o++) rc(o[4:0]);
    chk_outs();
    // lane 0 disabled: the write must not land
    bus(1'b1, 7'h04, 8'hff, 4'he);
    rc(5'h01);
    bus(1'b0, 7'h0d, 8'h00);
    chk("misaligned", 8'h00, rdat);
    print_verdict();
  end
endmodule
`default_nettype wire

// File: verif/sfrb0_mem_model.sv
// data memory model behind the indirect access port
`timescale 1ns/1ns
`default_nettype none
module sfrb0_mem_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] addr_i,
  input  wire logic       we_i,
  input  wire logic       re_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o
);
  logic [7:0] mem [256];
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
  end
  // unselected: inverse value so stale data never passes
  assign rdata_o = re_i ? mem[addr_i] : ~mem[addr_i];
endmodule
`default_nettype wire

// File: verif/sfrb0_regmap_asserts.sv
// concurrent checks on the ports of the bank-zero register map
`timescale 1ns/1ns
`default_nettype none
module sfrb0_regmap_asserts (
  // clock, reset and bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [6:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // indirect port and peripheral state
  input wire logic        indirect_we_o,
  input wire logic [7:0]  indirect_wdata_o,
  input wire logic [7:0]  indirect_rdata_i,
  input wire logic [9:0]  converter_result_i,
  input wire logic        timer1_write_o,
  input wire logic [15:0] timer1_counter_o,
  input wire logic [7:0]  core_status_flags_o,
  input wire logic [7:0]  comparator_shared_config_o,
  input wire logic [7:0]  converter_control_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic       rd;
  logic [9:0] res_q;
  assign rd = wb_ack_o && !wb_we_i;
  // the read data register loads on the same edge that raises ack
  always_ff @(posedge clk_i) begin
    res_q <= converter_result_i;
  end
  ////////////////////////////////////////////////////////////
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_hi_zero;
    rd |-> wb_dat_o[31:8] == 24'h0;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper data set");
  property p_unmapped;
    rd && (wb_adr_i[1:0] != 2'h0 || wb_adr_i[6:2] inside {5'h06, 5'h08, 5'h09, 5'h0d,
      5'h18, 5'h1d}) |-> wb_dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("hole not zero");
  property p_ind_we;
    indirect_we_o |-> wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 7'h00
      && indirect_wdata_o == wb_dat_i[7:0];
  endproperty
  a_ind_we: assert property (p_ind_we) else $error("stray indirect write");
  property p_ind_rd;
    rd && wb_adr_i == 7'h00 |-> wb_dat_o[7:0] == $past(indirect_rdata_i);
  endproperty
  a_ind_rd: assert property (p_ind_rd) else $error("indirect read bad");
  property p_adrh;
    rd && wb_adr_i == 7'h78 |-> wb_dat_o[7:0] ==
      (converter_control_o[7] ? {6'h0, res_q[9:8]} : res_q[9:2]);
  endproperty
  a_adrh: assert property (p_adrh) else $error("result high bad");
  property p_t1_high;
    wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 7'h3c
      |-> timer1_counter_o[15:8] == wb_dat_i[7:0] ##[0:1] timer1_write_o;
  endproperty
  a_t1_high: assert property (p_t1_high) else $error("timer1 high bad");
  property p_reset;
    $past(rst_i) |-> core_status_flags_o == 8'h18 && comparator_shared_config_o == 8'h02
      && converter_control_o == 8'h00 && !wb_ack_o;
  endproperty
  a_reset: assert property (p_reset) else $error("reset value bad");
endmodule
bind sfrb0_regmap sfrb0_regmap_asserts u_chk (.*);
`default_nettype wire
